// ===== design/stage_two_completer.sv
// stage-two completer: drains requests, zero completions, bitstream forwarding
`timescale 1ns/100ps
`default_nettype none
module stage_two_completer #(
    parameter int MASK_W = 4,
    parameter logic [MASK_W-1:0] MASK_IDLE = '0
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic end_of_startup_flag_in,
    input wire logic [15:0] completer_id_in,
    input wire logic [MASK_W-1:0] user_ctl_in,
    output logic [MASK_W-1:0] core_ctl_out,
    input wire logic rx_valid_in,
    input wire logic [31:0] rx_data_in,
    input wire logic rx_sop_in,
    input wire logic rx_eop_in,
    input wire logic rx_bar0_hit_in,
    output logic rx_ready_out,
    input wire logic user_rx_ready_in,
    output logic tx_valid_out,
    output logic [31:0] tx_data_out,
    output logic tx_last_out,
    input wire logic tx_ready_in,
    input wire logic user_tx_valid_in,
    input wire logic [31:0] user_tx_data_in,
    input wire logic user_tx_last_in,
    output logic user_tx_ready_out,
    output logic cfg_valid_out,
    output logic [31:0] cfg_data_out,
    input wire logic cfg_ready_in,
    output logic stage_two_ready_out
);
    if (MASK_W < 1) begin
        $error("MASK_W must be at least 1");
    end
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BODY = 3'b010,
        ST_CPL = 3'b100
    } state_t;
    state_t state;
    logic ready;
    logic load_done;
    logic [3:0] wait_cnt;
    logic [2:0] idx;
    logic [2:0] hdr_len;
    logic is_read;
    logic is_fwd;
    logic is_vdm;
    logic [15:0] req_id;
    logic [7:0] tag;
    logic [6:0] low_addr;
    logic [1:0] cw;
    logic own_tx_valid;
    logic [31:0] own_tx_data;
    logic own_ready;
    logic take;
    logic buf_in_valid;
    logic buf_in_ready;
    logic buf_empty;
    logic payload_word;
    // masked inputs: deasserted until stage two is live
    assign core_ctl_out = ready ? user_ctl_in : MASK_IDLE; // [R1] [R2] [R3]
    // own intake stalls on buffer back-pressure and in ST_CPL, and freezes in ST_IDLE once load ends
    assign own_ready = (state != ST_CPL) && buf_in_ready && !(load_done && state == ST_IDLE); // [R4]
    assign rx_ready_out = ready ? user_rx_ready_in : own_ready; // [R9]
    assign take = rx_valid_in && own_ready && !ready;
    assign payload_word = (state == ST_BODY) && (idx >= hdr_len);
    assign buf_in_valid = take && payload_word && is_fwd; // [R7] [R8] [R6]
    assign tx_valid_out = ready ? user_tx_valid_in : own_tx_valid; // [R9]
    assign tx_data_out = ready ? user_tx_data_in : own_tx_data;
    assign tx_last_out = ready ? user_tx_last_in : (own_tx_valid && cw == stage_two_pkg::CPL_LAST);
    assign user_tx_ready_out = ready && tx_ready_in;
    assign stage_two_ready_out = ready;
    function automatic logic [31:0] cpl_word(input logic [1:0] n, input logic [15:0] cid,
                                             input logic [15:0] rid, input logic [7:0] tg,
                                             input logic [6:0] la);
        logic [31:0] w;
        w = stage_two_pkg::CPL_PAYLOAD;
        unique case (n)
            2'h0: w = stage_two_pkg::CPL_DW0;
            2'h1: w = {cid, stage_two_pkg::CPL_STATUS_OK, 1'b0, stage_two_pkg::CPL_BYTE_COUNT};
            2'h2: w = {rid, tg, 1'b0, la};
            2'h3: w = stage_two_pkg::CPL_PAYLOAD;
        endcase
        return w;
    endfunction
    // request framing and decode
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= ST_IDLE;
            idx <= 3'h0;
            hdr_len <= stage_two_pkg::HDR_LEN_3DW;
            is_read <= 1'b0;
            is_fwd <= 1'b0;
            is_vdm <= 1'b0;
            req_id <= 16'h0000;
            tag <= 8'h00;
            low_addr <= 7'h00;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (take && rx_sop_in) begin
                        idx <= 3'h1;
                        hdr_len <= rx_data_in[stage_two_pkg::FMT_4DW_BIT] ?
                                   stage_two_pkg::HDR_LEN_4DW : stage_two_pkg::HDR_LEN_3DW;
                        is_read <= !rx_data_in[stage_two_pkg::FMT_DATA_BIT] &&
                                   rx_data_in[stage_two_pkg::TYPE_MSB:stage_two_pkg::TYPE_LSB] ==
                                   stage_two_pkg::TYPE_MEM; // [R5]
                        is_fwd <= rx_data_in[stage_two_pkg::FMT_DATA_BIT] && rx_bar0_hit_in &&
                                  rx_data_in[stage_two_pkg::TYPE_MSB:stage_two_pkg::TYPE_LSB] ==
                                  stage_two_pkg::TYPE_MEM; // [R7]
                        is_vdm <= rx_data_in[stage_two_pkg::TYPE_MSB:stage_two_pkg::TYPE_MSB-1] ==
                                  stage_two_pkg::TYPE_MSG_TOP; // [R6]
                        state <= ST_BODY;
                    end
                end
                ST_BODY: begin
                    if (take) begin
                        if (idx == 3'h1) begin
                            req_id <= rx_data_in[31:stage_two_pkg::REQ_ID_LSB]; // [R14]
                            tag <= rx_data_in[stage_two_pkg::REQ_ID_LSB-1:stage_two_pkg::TAG_LSB];
                        end
                        if (idx == 3'(hdr_len - 3'h1)) begin
                            low_addr <= rx_data_in[6:0];
                        end
                        if (idx != stage_two_pkg::IDX_MAX) begin
                            idx <= 3'(idx + 3'h1);
                        end
                        if (rx_eop_in) begin
                            state <= is_read ? ST_CPL : ST_IDLE; // [R4] [R6]
                        end
                    end
                end
                ST_CPL: begin
                    if (own_tx_valid && tx_ready_in && cw == stage_two_pkg::CPL_LAST) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end
    // zero-data completion sender
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            own_tx_valid <= 1'b0;
            own_tx_data <= 32'h00000000;
            cw <= 2'h0;
        end else if (state == ST_BODY && take && rx_eop_in && is_read) begin
            own_tx_valid <= 1'b1;
            cw <= 2'h0;
            own_tx_data <= cpl_word(2'h0, completer_id_in, req_id, tag, low_addr); // [R5] [R14]
        end else if (own_tx_valid && tx_ready_in) begin
            if (cw == stage_two_pkg::CPL_LAST) begin
                own_tx_valid <= 1'b0;
            end else begin
                cw <= 2'(cw + 2'h1);
                own_tx_data <= cpl_word(2'(cw + 2'h1), completer_id_in, req_id, tag, low_addr);
            end
        end
    end
    // end-of-startup detection and ready delay
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            load_done <= 1'b0;
            wait_cnt <= 4'h0;
            ready <= 1'b0;
        end else begin
            if (end_of_startup_flag_in) begin
                load_done <= 1'b1; // [R12]
            end
            if (load_done && !ready && wait_cnt != stage_two_pkg::READY_FORCE_CYC) begin
                wait_cnt <= 4'(wait_cnt + 4'h1);
            end
            if (load_done && !ready && wait_cnt + 4'h2 >= stage_two_pkg::READY_DELAY_CYC &&
                ((state == ST_IDLE && buf_empty) || wait_cnt + 4'h2 >= stage_two_pkg::READY_FORCE_CYC)) begin
                ready <= 1'b1; // [R11] [R9]
            end
        end
    end
    two_entry_buffer #(
        .WIDTH(stage_two_pkg::DW_W),
        .DEPTH(stage_two_pkg::BUF_DEPTH)
    ) u_payload_buf (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .in_valid_in(buf_in_valid),
        .in_data_in(rx_data_in),
        .in_ready_out(buf_in_ready),
        .out_valid_out(cfg_valid_out),
        .out_data_out(cfg_data_out),
        .out_ready_in(cfg_ready_in),
        .empty_out(buf_empty)
    );
    sequence s_startup_rise;
        end_of_startup_flag_in && !load_done;
    endsequence
    sequence s_ready_late;
        !ready [*2] ##[0:10] ready;
    endsequence
    a_ready_window: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_startup_rise |=> s_ready_late) // [R11]
        else $error("ready not within 2 to 12 cycles of end of startup");
    a_mask_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !stage_two_ready_out |-> core_ctl_out == MASK_IDLE) // [R2]
        else $error("masked input leaked before ready");
    a_pass_user: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        stage_two_ready_out |-> core_ctl_out == user_ctl_in && rx_ready_out == user_rx_ready_in) // [R3]
        else $error("user signals not passed after ready");
    a_drain_rx: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !load_done && state == ST_BODY && buf_in_ready |-> rx_ready_out) // [R4]
        else $error("request body not drained");
    a_cpl_frame: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        state == ST_BODY && take && rx_eop_in && is_read |=>
        tx_valid_out && tx_data_out == stage_two_pkg::CPL_DW0) // [R5]
        else $error("read did not start a completion");
    a_cpl_ids: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        own_tx_valid && cw == 2'h2 |-> own_tx_data == {req_id, tag, 1'b0, low_addr}) // [R14]
        else $error("completion requester id or tag wrong");
    a_cpl_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        own_tx_valid && cw == stage_two_pkg::CPL_LAST |-> own_tx_data == 32'h00000000 && tx_last_out) // [R5]
        else $error("completion payload not zero");
    a_vdm_drop: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        state == ST_BODY && is_vdm |-> !buf_in_valid ##1 !own_tx_valid) // [R6]
        else $error("vendor message not discarded");
    a_fwd_payload: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        take && payload_word && is_fwd |-> buf_in_valid && buf_in_ready) // [R8] [R15]
        else $error("bitstream word not forwarded");
    a_inactive: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        stage_two_ready_out |-> state == ST_IDLE && !own_tx_valid && !buf_in_valid) // [R9]
        else $error("completer active after ready");
endmodule
`default_nettype wire

// ===== design/stage_two_pkg.sv
// constants and functional notes for the stage-two bitstream completer
// Functional notes
// [R1] masked core inputs selected by stage-two-ready
// [R2] masked inputs held deasserted while loading
// [R3] after ready, user signals pass through
// [R4] drain every received request in stage one
// [R5] host reads 1DW; answer zero-data completion
// [R6] vendor messages dropped without further action
// [R7] first-BAR memory writes are bitstream data
// [R8] bitstream payload goes to config port
// [R9] completer inactive once stage-two-ready asserted; forced ready at READY_FORCE_CYC skips the ST_IDLE and empty-buffer wait
// [R10] host sends config data 32-bit aligned
// [R11] ready asserts 2 to 12 cycles after load
// [R12] end-of-startup flag marks stage-two completion
// [R13] user leaves config/startup ports until ready
// [R14] completion returns requester id, tag, success
// [R15] payload words forwarded in order, none lost
package stage_two_pkg;
    localparam int DW_W = 32;
    localparam int FMT_MSB = 31;
    localparam int FMT_LSB = 29;
    localparam int FMT_4DW_BIT = 29;
    localparam int FMT_DATA_BIT = 30;
    localparam int TYPE_MSB = 28;
    localparam int TYPE_LSB = 24;
    localparam logic [4:0] TYPE_MEM = 5'h00;
    localparam logic [1:0] TYPE_MSG_TOP = 2'h2;
    localparam int REQ_ID_LSB = 16;
    localparam int TAG_LSB = 8;
    localparam logic [31:0] CPL_DW0 = 32'h4a000001;
    localparam logic [2:0] CPL_STATUS_OK = 3'h0;
    localparam logic [11:0] CPL_BYTE_COUNT = 12'h004;
    localparam logic [31:0] CPL_PAYLOAD = 32'h00000000;
    localparam logic [1:0] CPL_LAST = 2'h3;
    localparam logic [2:0] HDR_LEN_3DW = 3'h3;
    localparam logic [2:0] HDR_LEN_4DW = 3'h4;
    localparam logic [2:0] IDX_MAX = 3'h4;
    localparam int CLK_PERIOD_NS = 25;
    localparam int READY_MIN_CYC = 2;
    localparam int READY_MAX_CYC = 12;
    localparam logic [3:0] READY_DELAY_CYC = 4'h4;
    localparam logic [3:0] READY_FORCE_CYC = 4'hc;
    localparam int BUF_DEPTH = 2;
endpackage

// ===== design/two_entry_buffer.sv
// two-entry valid/ready buffer in the payload path
`timescale 1ns/100ps
`default_nettype none
module two_entry_buffer #(
    parameter int WIDTH = stage_two_pkg::DW_W,
    parameter int DEPTH = stage_two_pkg::BUF_DEPTH
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in,
    output logic empty_out
);
    if (DEPTH != 2 || WIDTH < 1) begin
        $error("two_entry_buffer needs DEPTH 2 and WIDTH >= 1");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;
    assign in_ready_out = (count != 2'h2);
    assign out_valid_out = (count != 2'h0);
    assign empty_out = (count == 2'h0);
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in; // [R15]
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= 2'(count + {1'b0, push} - {1'b0, pop});
        end
    end
    a_no_overflow: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        count == 2'h2 && !pop |=> count == 2'h2 && $stable(mem[0]) && $stable(mem[1])) // [R15]
        else $error("buffer entry lost while full");
endmodule
`default_nettype wire

// ===== tb/host_model.sv
// host-side stream model: feeds request beats, takes completion beats
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clk_in,
    input wire logic arst_n_in,
    output logic rx_valid_out,
    output logic [31:0] rx_data_out,
    output logic rx_sop_out,
    output logic rx_eop_out,
    output logic rx_bar0_hit_out,
    input wire logic rx_ready_in,
    input wire logic tx_valid_in,
    input wire logic [31:0] tx_data_in,
    input wire logic tx_last_in,
    output logic tx_ready_out
);
    logic [34:0] rxq[$];
    logic [32:0] txq[$];
    logic slow = 1'b0;
    // reads one dword long, payload whole 32-bit words
    task automatic push(input logic s, input logic e, input logic b, input logic [31:0] d);
        rxq.push_back({s, e, b, d});
    endtask
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_valid_out <= 1'b0;
            {rx_sop_out, rx_eop_out, rx_bar0_hit_out} <= 3'h0;
            rx_data_out <= 32'h0;
        end else if (!rx_valid_out || rx_ready_in) begin
            if (rxq.size() > 0) begin
                {rx_sop_out, rx_eop_out, rx_bar0_hit_out, rx_data_out} <= rxq.pop_front();
                rx_valid_out <= 1'b1;
            end else begin
                rx_valid_out <= 1'b0;
                rx_data_out <= ~rx_data_out;
            end
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tx_ready_out <= 1'b0;
        end else begin
            tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
        end
    end
    always @(posedge clk_in) begin
        if (tx_valid_in === 1'b1 && tx_ready_out) begin
            txq.push_back({tx_last_in, tx_data_in});
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// testbench for the stage-two completer
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic end_of_startup_flag = 1'b0;
    logic [15:0] cid = 16'h0a31;
    logic [3:0] user_ctl = 4'h0;
    logic user_rx_ready = 1'b0;
    logic user_tx_valid = 1'b0;
    logic [31:0] user_tx_data = 32'h0;
    logic user_tx_last = 1'b0;
    logic cfg_ready = 1'b1;
    logic [3:0] core_ctl;
    logic rx_valid, rx_sop, rx_eop, rx_bar0_hit, rx_ready, tx_valid, tx_last, tx_ready;
    logic user_tx_ready, cfg_valid, stage_two_ready;
    logic [31:0] rx_data, tx_data, cfg_data;
    logic [31:0] cfgq[$];
    int error_cnt = 0;
    int compares = 0;
    always #12.5 clk_in = ~clk_in;
    stage_two_completer DUT (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .end_of_startup_flag_in(end_of_startup_flag), .completer_id_in(cid), .user_ctl_in(user_ctl),
        .core_ctl_out(core_ctl), .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_sop_in(rx_sop),
        .rx_eop_in(rx_eop), .rx_bar0_hit_in(rx_bar0_hit), .rx_ready_out(rx_ready),
        .user_rx_ready_in(user_rx_ready), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
        .tx_last_out(tx_last), .tx_ready_in(tx_ready), .user_tx_valid_in(user_tx_valid),
        .user_tx_data_in(user_tx_data), .user_tx_last_in(user_tx_last), .user_tx_ready_out(user_tx_ready),
        .cfg_valid_out(cfg_valid), .cfg_data_out(cfg_data), .cfg_ready_in(cfg_ready),
        .stage_two_ready_out(stage_two_ready));
    host_model host (.clk_in(clk_in), .arst_n_in(arst_n_in), .rx_valid_out(rx_valid),
        .rx_data_out(rx_data), .rx_sop_out(rx_sop), .rx_eop_out(rx_eop), .rx_bar0_hit_out(rx_bar0_hit),
        .rx_ready_in(rx_ready), .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_last_in(tx_last),
        .tx_ready_out(tx_ready));
    always @(posedge clk_in) begin
        if (cfg_valid === 1'b1 && cfg_ready) begin
            cfgq.push_back(cfg_data);
        end
    end
    task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic push_read;
        host.push(1'b1, 1'b0, 1'b0, 32'h00000001);
        host.push(1'b0, 1'b0, 1'b0, {16'h1234, 8'h5a, 8'h0f});
        host.push(1'b0, 1'b1, 1'b0, 32'h00000014);
    endtask
    task automatic test_mask;
        @(posedge clk_in) user_ctl <= 4'hf;
        @(negedge clk_in);
        chk("core ctl masked", 33'h0, {29'h0, core_ctl});
        chk("ready low", 33'h0, {32'h0, stage_two_ready});
        chk("user tx ready masked", 33'h0, {32'h0, user_tx_ready});
    endtask
    task automatic test_read;
        host.slow = 1'b1;
        push_read();
        for (int i = 0; i < 200 && host.txq.size() < 4; i++) @(negedge clk_in);
        chk("cpl dw0", {1'b0, 32'h4a000001}, host.txq[0]);
        chk("cpl dw1", {1'b0, cid, 16'h0004}, host.txq[1]);
        chk("cpl dw2", {1'b0, 16'h1234, 8'h5a, 1'b0, 7'h14}, host.txq[2]);
        chk("cpl dw3", {1'b1, 32'h0}, host.txq[3]);
        host.txq.delete();
        host.slow = 1'b0;
    endtask
    task automatic test_drop;
        host.push(1'b1, 1'b0, 1'b0, 32'h30000000);
        repeat (2) host.push(1'b0, 1'b0, 1'b0, 32'h0);
        host.push(1'b0, 1'b1, 1'b0, 32'h0);
        host.push(1'b1, 1'b0, 1'b0, 32'h40000001);
        repeat (2) host.push(1'b0, 1'b0, 1'b0, 32'h0);
        host.push(1'b0, 1'b1, 1'b0, 32'hdeadbeef);
        push_read();
        for (int i = 0; i < 200 && host.txq.size() < 4; i++) @(negedge clk_in);
        chk("cpl after drop", {1'b1, 32'h0}, host.txq[3]);
        chk("no cfg word", 33'h0, 33'(cfgq.size()));
        host.txq.delete();
    endtask
    task automatic test_write;
        @(posedge clk_in) cfg_ready <= 1'b0;
        host.push(1'b1, 1'b0, 1'b1, 32'h40000004);
        repeat (2) host.push(1'b0, 1'b0, 1'b0, 32'h0);
        for (int i = 0; i < 4; i++) host.push(1'b0, i == 3, 1'b0, 32'hc0de0000 + i);
        repeat (20) @(negedge clk_in);
        chk("cfg stalled valid", 33'h1, {32'h0, cfg_valid});
        chk("rx stalled", 33'h0, {32'h0, rx_ready});
        @(posedge clk_in) cfg_ready <= 1'b1;
        host.push(1'b1, 1'b0, 1'b1, 32'h60000002);
        repeat (3) host.push(1'b0, 1'b0, 1'b0, 32'h0);
        host.push(1'b0, 1'b0, 1'b0, 32'hc0de0004);
        host.push(1'b0, 1'b1, 1'b0, 32'hc0de0005);
        for (int i = 0; i < 200 && cfgq.size() < 6; i++) @(negedge clk_in);
        for (int i = 0; i < 6; i++) chk("cfg word", {1'b0, 32'hc0de0000 + i}, {1'b0, cfgq[i]});
        chk("cfg count", 33'h6, 33'(cfgq.size()));
    endtask
    task automatic test_ready;
        int n;
        @(posedge clk_in);
        user_ctl <= 4'ha;
        end_of_startup_flag <= 1'b1;
        @(posedge clk_in) end_of_startup_flag <= 1'b0;
        for (n = 1; n <= 20; n++) begin
            @(negedge clk_in);
            if (stage_two_ready === 1'b1) break;
        end
        chk("ready delay", 33'h1, {32'h0, n >= stage_two_pkg::READY_MIN_CYC + 1 && n <= stage_two_pkg::READY_MAX_CYC + 1});
        chk("core ctl pass", {29'h0, 4'ha}, {29'h0, core_ctl});
        chk("rx ready user", 33'h0, {32'h0, rx_ready});
        @(posedge clk_in);
        user_rx_ready <= 1'b1;
        user_tx_valid <= 1'b1;
        user_tx_data <= 32'h5eed0001;
        user_tx_last <= 1'b1;
        @(negedge clk_in);
        chk("rx ready user", 33'h1, {32'h0, rx_ready});
        chk("tx pass", {1'b1, 32'h5eed0001}, {tx_last, tx_data});
        chk("tx valid pass", 33'h1, {32'h0, tx_valid});
        chk("tx ready pass", {32'h0, tx_ready}, {32'h0, user_tx_ready});
        @(posedge clk_in) user_tx_valid <= 1'b0;
        @(negedge clk_in);
        host.txq.delete();
        push_read();
        repeat (20) @(negedge clk_in);
        chk("no cpl after ready", 33'h0, 33'(host.txq.size()));
        chk("ready sticky", 33'h1, {32'h0, stage_two_ready});
    endtask
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(negedge clk_in);
        test_mask();
        test_read();
        test_drop();
        test_write();
        test_ready();
        stop_test();
    end
endmodule
`default_nettype wire
